// *** seq_pkg.sv ***
// shared constants and carrier types for the buck startup and fault sequencer
`default_nettype none
package seq_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned HICCUP_US = 5000;
  localparam int unsigned HICCUP_CYC = (CLK_HZ / 1000000) * HICCUP_US;
  localparam int unsigned SOFTSTART_NS = 1280000;
  localparam int unsigned SS_STEPS = 128;
  localparam int unsigned SS_STEP_CYC =
    ((CLK_HZ / 1000000) * SOFTSTART_NS + 1000 * SS_STEPS - 1) /
    (1000 * SS_STEPS);
  localparam int unsigned CAL_CYC = 512;
  localparam int unsigned OC_WINDOW = 32;
  localparam int unsigned OC_LIMIT = 5;

  // comparator inputs from the analog side
  typedef struct packed {
    logic enable_above;      // enable pin above its rising threshold
    logic current_limit;     // current_limit_event comparator
    logic ss_above_fb;       // soft-start pin above feedback_sense
    logic ss_above_ref;      // soft-start pin above reference
    logic ss_cap_present;    // external soft-start capacitor fitted
    logic ss_above_91;       // soft-start pin above 91 % of reference
    logic ss_below_87;       // soft-start pin below 87 % of reference
    logic fb_above_91;       // feedback_sense above 91 % of reference
    logic fb_below_87;       // feedback_sense below 87 % of reference
    logic pwm_demand;        // modulator asks for a high-side pulse
  } comp_in_t;

  // gate and analog-side controls
  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
    logic ss_pulldown;       // discharge the soft-start pin
    logic comp_clamp;        // hold the compensation node at lower clamp
    logic neg_current_ok;    // permit negative inductor current
    logic track_ss_pin;      // regulate to soft-start pin, not reference
  } gate_out_t;
endpackage
`default_nettype wire

// *** oc_window.sv ***
// sliding 32-cycle overcurrent event window with population count
`timescale 1ns/1ns
`default_nettype none
module oc_window #(
  parameter int unsigned WINDOW = 32,
  parameter int unsigned LIMIT = 5
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic event_in,
  output logic trip
);
  logic [WINDOW-1:0] hist_r;

  function automatic logic [$clog2(WINDOW+1)-1:0] popcount(
    input logic [WINDOW-1:0] v);
    logic [$clog2(WINDOW+1)-1:0] n;
    n = '0;
    for (int i = 0; i < WINDOW; i++) begin
      n = n + {{($clog2(WINDOW+1)-1){1'b0}}, v[i]};
    end
    return n;
  endfunction

  // history shifts in each event on the next edge
  always_ff @(posedge mclk) begin
    if (!resetn || clear) begin
      hist_r <= '0;
    end else begin
      hist_r <= {hist_r[WINDOW-2:0], event_in};
    end
  end

  // compared every cycle against the threshold
  assign trip = (popcount(hist_r) >=
    ($clog2(WINDOW+1))'(LIMIT));
endmodule
`default_nettype wire

// *** buck_startup_fault_sequencer.sv ***
// startup, soft-start, hiccup and power-good sequencer of a buck controller
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - five overcurrent events in 32 cycles: hiccup
// - hiccup holds both gates off for 5 ms
// - no negative inductor current during hiccup
// - after hiccup restart through normal startup
// - current limit: high gate off, low on
// - start only after enable comparator rises
// - internal soft-start of 128 steps, 1.28 ms
// - power good above 91%, low below 87%
// - tracking keeps internal soft-start active
// - follow soft-start pin up to reference
// - 512-cycle calibration before soft-start release
// - no switching until soft-start reaches feedback or reference
// - then synchronous switching, negative current allowed
// - prebiased start below reference never pulls output low
// - discharge soft-start pin before start, restart
// - both gates low while soft-start below feedback and reference
// - release comp clamp; switch above fb or ref
// - power good when feedback (soft-start pin before first pulse) reaches 91%
// - power good = soft-start done AND undervoltage AND running
// - undervoltage watches soft-start, then feedback
// - event counted next edge; five triggers hiccup
module buck_startup_fault_sequencer #(
  parameter int unsigned HICCUP_CYCLES = seq_pkg::HICCUP_CYC,
  parameter int unsigned CAL_CYCLES = seq_pkg::CAL_CYC,
  parameter int unsigned SS_STEP_CYCLES = seq_pkg::SS_STEP_CYC,
  parameter int unsigned SS_STEPS = seq_pkg::SS_STEPS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire seq_pkg::comp_in_t comp_in,
  output seq_pkg::gate_out_t gate_out,
  output logic power_good_flag,
  output logic soft_start_done,
  output logic hiccup_active
);
  typedef enum logic [2:0] {
    ST_OFF, ST_CAL, ST_WAIT_SS, ST_RUN, ST_HICCUP
  } state_t;

  localparam int HW = $clog2(HICCUP_CYCLES + 1);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  localparam int SW = $clog2(SS_STEP_CYCLES + 1);
  localparam int NW = $clog2(SS_STEPS + 1);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  seq_pkg::comp_in_t meta_r;
  seq_pkg::comp_in_t sync_r;

  // comparators are asynchronous to mclk, two flops before any use
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= comp_in;
      sync_r <= meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overcurrent window
  state_t state_r;
  state_t state_nxt;
  logic oc_trip;

  // history is flushed outside running so old events cannot re-trip
  oc_window #(
    .WINDOW(seq_pkg::OC_WINDOW),
    .LIMIT(seq_pkg::OC_LIMIT)
  ) u_oc_window (
    .mclk(mclk),
    .resetn(resetn),
    .clear(state_r != ST_RUN),
    .event_in(sync_r.current_limit),
    .trip(oc_trip)
  );

  ////////////////////////////////////////////////////////////////////////
  // counters
  logic [HW-1:0] hic_cnt_r;
  logic [CW-1:0] cal_cnt_r;
  logic [SW-1:0] step_cnt_r;
  logic [NW-1:0] ss_step_r;
  logic ss_done;
  logic first_pulse_r;

  assign ss_done = (ss_step_r == NW'(SS_STEPS));

  // hiccup timer runs only inside the hiccup state
  always_ff @(posedge mclk) begin
    if (!resetn || state_r != ST_HICCUP) begin
      hic_cnt_r <= '0;
    end else if (hic_cnt_r != HW'(HICCUP_CYCLES)) begin
      hic_cnt_r <= hic_cnt_r + HW'(1);
    end
  end

  // calibration delay after the enable crossing
  always_ff @(posedge mclk) begin
    if (!resetn || state_r != ST_CAL) begin
      cal_cnt_r <= '0;
    end else if (cal_cnt_r != CW'(CAL_CYCLES)) begin
      cal_cnt_r <= cal_cnt_r + CW'(1);
    end
  end

  // internal digital soft-start runs in waiting and running, capacitor or tracking too
  always_ff @(posedge mclk) begin
    if (!resetn || state_r == ST_OFF || state_r == ST_CAL ||
        state_r == ST_HICCUP) begin
      step_cnt_r <= '0;
      ss_step_r <= '0;
    end else if (!ss_done) begin
      if (step_cnt_r == SW'(SS_STEP_CYCLES - 1)) begin
        step_cnt_r <= '0;
        ss_step_r <= ss_step_r + NW'(1);
      end else begin
        step_cnt_r <= step_cnt_r + SW'(1);
      end
    end
  end

  // marks the first modulator pulse of this start
  always_ff @(posedge mclk) begin
    if (!resetn || state_r != ST_RUN) begin
      first_pulse_r <= 1'b0;
    end else if (sync_r.pwm_demand) begin
      first_pulse_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (sync_r.enable_above) begin
          state_nxt = ST_CAL;
        end
      end
      ST_CAL: begin
        if (!sync_r.enable_above) begin
          state_nxt = ST_OFF;
        end else if (cal_cnt_r == CW'(CAL_CYCLES)) begin
          state_nxt = ST_WAIT_SS;
        end
      end
      ST_WAIT_SS: begin
        if (!sync_r.enable_above) begin
          state_nxt = ST_OFF;
        end else if (sync_r.ss_above_fb || sync_r.ss_above_ref) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!sync_r.enable_above) begin
          state_nxt = ST_OFF;
        end else if (oc_trip) begin
          state_nxt = ST_HICCUP;
        end
      end
      ST_HICCUP: begin
        if (hic_cnt_r == HW'(HICCUP_CYCLES)) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate and analog control outputs
  seq_pkg::gate_out_t go_nxt;

  // gates low outside running; a current limit cuts the high side
  always_comb begin
    go_nxt = '0;
    // pin held low in off, calibration and hiccup: restart is clean
    go_nxt.ss_pulldown = (state_nxt == ST_OFF || state_nxt == ST_CAL ||
      state_nxt == ST_HICCUP);
    go_nxt.comp_clamp = (state_nxt != ST_RUN);
    go_nxt.track_ss_pin = !sync_r.ss_above_ref;
    if (state_nxt == ST_RUN) begin
      go_nxt.neg_current_ok = 1'b1;
      if (sync_r.current_limit) begin
        go_nxt.high_side_gate = 1'b0;
        go_nxt.low_side_gate = 1'b1;
      end else begin
        go_nxt.high_side_gate = sync_r.pwm_demand;
        go_nxt.low_side_gate = !sync_r.pwm_demand;
      end
    end
    // waiting and hiccup keep both gates low, so the low side never
    // sinks current from a prebiased or recovering output
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gate_out <= '0;
      gate_out.ss_pulldown <= 1'b1;
      gate_out.comp_clamp <= 1'b1;
    end else begin
      gate_out <= go_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power good with hysteresis
  logic uv_ok_r;
  logic uv_rise;
  logic uv_fall;

  // watch the soft-start pin until the first pulse, feedback afterwards
  always_comb begin
    if (first_pulse_r) begin
      uv_rise = sync_r.fb_above_91;
      uv_fall = sync_r.fb_below_87;
    end else begin
      uv_rise = sync_r.ss_above_91;
      uv_fall = sync_r.ss_below_87;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || state_r != ST_RUN) begin
      uv_ok_r <= 1'b0;
    end else if (uv_rise) begin
      uv_ok_r <= 1'b1;
    end else if (uv_fall) begin
      uv_ok_r <= 1'b0;
    end
  end

  // flag is the AND of soft-start done, the undervoltage state and ST_RUN
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      power_good_flag <= 1'b0;
      soft_start_done <= 1'b0;
      hiccup_active <= 1'b0;
    end else begin
      power_good_flag <= ss_done && uv_ok_r &&
        (state_r == ST_RUN);
      soft_start_done <= ss_done;
      hiccup_active <= (state_nxt == ST_HICCUP);
    end
  end
endmodule
`default_nettype wire

// *** seq_properties.sv ***
// port-level assertions for the startup and fault sequencer
`timescale 1ns/1ns
`default_nettype none
module seq_properties #(
  parameter int unsigned HICCUP_CYCLES = 50,
  parameter int unsigned CAL_CYCLES = 8,
  parameter int unsigned SS_STEP_CYCLES = 2,
  parameter int unsigned SS_STEPS = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire seq_pkg::comp_in_t comp_in,
  input wire seq_pkg::gate_out_t gate_out,
  input wire logic power_good_flag,
  input wire logic soft_start_done,
  input wire logic hiccup_active
);
  localparam int unsigned SS_T = SS_STEPS * SS_STEP_CYCLES;
  logic [31:0] hic_r;
  logic [31:0] en_r;
  logic [31:0] rel_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // run lengths: wide enough for the full-length hiccup count too
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hic_r <= 32'h0;
      en_r <= 32'h0;
      rel_r <= 32'h0;
    end else begin
      hic_r <= hiccup_active ? hic_r + 32'h1 : 32'h0;
      en_r <= comp_in.enable_above ? en_r + 32'h1 : 32'h0;
      rel_r <= gate_out.ss_pulldown ? 32'h0 : rel_r + 32'h1;
    end
  end
  ////////////////////////////////////////
  // sync lag means each cause is judged a few edges later
  AST_HIC_TRIP: assert property (
    (comp_in.current_limit && gate_out.neg_current_ok)[*5] |->
    ##[0:4] hiccup_active) else $error("no hiccup after five events");
  AST_HIC_GATES: assert property (hiccup_active |->
    !gate_out.high_side_gate && !gate_out.low_side_gate &&
    !gate_out.neg_current_ok) else $error("switching during hiccup");
  AST_HIC_LEN: assert property ($fell(hiccup_active) |->
    hic_r >= HICCUP_CYCLES && hic_r <= HICCUP_CYCLES + 1)
    else $error("hiccup length wrong");
  AST_HIC_PD: assert property (hiccup_active |->
    gate_out.ss_pulldown) else $error("pin not discharged");
  AST_CL_RESP: assert property (
    ($rose(comp_in.current_limit) && gate_out.neg_current_ok) ##1
    comp_in.current_limit[*2] |-> ##1 (!gate_out.high_side_gate &&
    (gate_out.low_side_gate || hiccup_active)))
    else $error("limit response wrong");
  AST_GATES_WAIT: assert property (
    (!comp_in.ss_above_fb && !comp_in.ss_above_ref)[*3] |->
    !gate_out.high_side_gate && !gate_out.low_side_gate)
    else $error("gates on below feedback");
  AST_CAL_DELAY: assert property ($fell(gate_out.ss_pulldown) |->
    en_r >= CAL_CYCLES) else $error("pin released early");
  AST_SS_DONE: assert property ($rose(soft_start_done) |->
    rel_r >= SS_T && rel_r <= SS_T + 2) else $error("soft-start time");
  AST_PG_DONE: assert property ($rose(power_good_flag) |->
    $past(soft_start_done)) else $error("good before done");
  AST_PG_HIC: assert property (hiccup_active |->
    ##1 !power_good_flag) else $error("good during hiccup");
endmodule
bind buck_startup_fault_sequencer seq_properties #(
  .HICCUP_CYCLES(HICCUP_CYCLES),
  .CAL_CYCLES(CAL_CYCLES),
  .SS_STEP_CYCLES(SS_STEP_CYCLES),
  .SS_STEPS(SS_STEPS)
) u_props (
  .mclk(mclk),
  .resetn(resetn),
  .comp_in(comp_in),
  .gate_out(gate_out),
  .power_good_flag(power_good_flag),
  .soft_start_done(soft_start_done),
  .hiccup_active(hiccup_active)
);
`default_nettype wire

// *** comp_model.sv ***
// comparator, soft-start pin and feedback model on the analog side
`timescale 1ns/1ns
`default_nettype none
module comp_model (
  input wire logic mclk,
  input wire logic en,
  input wire logic cl,
  input wire logic pwm,
  input wire logic [7:0] fb_lvl,
  input wire seq_pkg::gate_out_t gate_out,
  output seq_pkg::comp_in_t comp_in
);
  logic [7:0] ss_r = 8'h00;
  logic [7:0] fb_r = 8'h00;
  // pin ramps a step a cycle; reference is 3C, final value 50
  always_ff @(posedge mclk) begin
    if (gate_out.ss_pulldown) begin
      ss_r <= 8'h00;
    end else if (ss_r < 8'h50) begin
      ss_r <= ss_r + 8'h01;
    end
  end
  // feedback holds the prebias until switching, then follows the pin up to 3C
  always_ff @(posedge mclk) begin
    if (gate_out.high_side_gate || gate_out.low_side_gate) begin
      fb_r <= (ss_r > 8'h3C) ? 8'h3C : ss_r;
    end else begin
      fb_r <= fb_lvl;
    end
  end
  ////////////////////////////////////////
  // thresholds: 91 % is 37, 87 % is 34 in pin steps
  always_comb begin
    comp_in.enable_above = en;
    comp_in.current_limit = cl;
    comp_in.ss_above_fb = ss_r > fb_r;
    comp_in.ss_above_ref = ss_r >= 8'h3C;
    comp_in.ss_cap_present = 1'h0;
    comp_in.ss_above_91 = ss_r >= 8'h37;
    comp_in.ss_below_87 = ss_r < 8'h34;
    comp_in.fb_above_91 = fb_r >= 8'h37;
    comp_in.fb_below_87 = fb_r < 8'h34;
    comp_in.pwm_demand = pwm;
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the startup and fault sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int HIC = 50;
  localparam int CAL = 8;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic en = 1'h0;
  logic cl = 1'h0;
  logic pwm = 1'h0;
  logic [7:0] fb_lvl = 8'h1E;
  seq_pkg::comp_in_t comp_in;
  seq_pkg::gate_out_t g;
  logic pg;
  logic done;
  logic hic;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  initial begin
    forever #10 mclk = ~mclk;
  end
  comp_model u_model (.mclk(mclk), .en(en), .cl(cl), .pwm(pwm),
    .fb_lvl(fb_lvl), .gate_out(g), .comp_in(comp_in));
  buck_startup_fault_sequencer #(.HICCUP_CYCLES(HIC), .CAL_CYCLES(CAL),
    .SS_STEP_CYCLES(2), .SS_STEPS(4)) DUT (.mclk(mclk), .resetn(resetn),
    .comp_in(comp_in), .gate_out(g), .power_good_flag(pg),
    .soft_start_done(done), .hiccup_active(hic));
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [3:0] e,
                     input logic [3:0] v);
    total_checks++;
    if (v !== e) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", s, e, v);
    end
  endtask
  // sample 1 ns after the edge so outputs have settled
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic t_start();
    tick(20);
    chk("enable wait", 4'h1, g.ss_pulldown);
    @(posedge mclk) en <= 1'h1;
    n = 0;
    while (g.ss_pulldown === 1'h1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("cal delay", 4'h1, n >= CAL);
    while (g.comp_clamp === 1'h1 && n < 300) begin
      chk("gates off", 4'h0, {g.high_side_gate, g.low_side_gate});
      tick(1);
      n++;
    end
    chk("switching", 4'h1, g.neg_current_ok);
    chk("track pin", 4'h1, g.track_ss_pin);
    @(posedge mclk) pwm <= 1'h1;
    tick(4);
    chk("pwm high", 4'h2, {g.high_side_gate, g.low_side_gate});
    @(posedge mclk) pwm <= 1'h0;
    tick(4);
    chk("pwm low", 4'h1, {g.high_side_gate, g.low_side_gate});
    n = 0;
    while (pg !== 1'h1 && n < 300) begin
      tick(1);
      n++;
    end
    chk("power good", 4'h3, {pg, done});
    @(posedge mclk) pwm <= 1'h1;
  endtask
  // four events stay one short of the trip count
  task automatic t_light();
    @(posedge mclk) cl <= 1'h1;
    repeat (3) @(posedge mclk);
    @(posedge mclk) cl <= 1'h0;
    #1;
    chk("limit gates", 4'h1, {g.high_side_gate, g.low_side_gate});
    tick(40);
    chk("four events", 4'h0, hic);
  endtask
  task automatic t_hiccup();
    @(posedge mclk) fb_lvl <= 8'h46;
    cl <= 1'h1;
    repeat (4) @(posedge mclk);
    @(posedge mclk) cl <= 1'h0;
    n = 0;
    while (hic !== 1'h1 && n < 10) begin
      tick(1);
      n++;
    end
    chk("hiccup", 4'h1, hic);
    chk("hiccup out", 4'h1, {g.high_side_gate, g.low_side_gate,
      g.neg_current_ok, g.ss_pulldown});
    n = 0;
    while (hic === 1'h1 && n < 200) begin
      tick(1);
      n++;
    end
    chk("hiccup len", 4'h1, n >= HIC - 1 && n <= HIC + 1);
    n = 0;
    while (g.ss_pulldown === 1'h1 && n < 100) begin
      tick(1);
      n++;
    end
    n = 0;
    while (g.comp_clamp === 1'h1 && n < 300) begin
      chk("prebias", 4'h0, {g.high_side_gate, g.low_side_gate});
      tick(1);
      n++;
    end
    chk("restart", 4'h1, n >= 55 && g.comp_clamp === 1'h0);
    chk("ref takes over", 4'h0, g.track_ss_pin);
  endtask
  // a reset in mid-run drops straight back to the discharged idle state
  task automatic t_midreset();
    @(posedge mclk) resetn <= 1'h0;
    tick(3);
    chk("mid reset", 4'hC, {g.ss_pulldown, g.comp_clamp, g.high_side_gate,
      g.low_side_gate});
    chk("mid reset flags", 4'h0, {pg, done, hic});
    @(posedge mclk) resetn <= 1'h1;
    tick(3);
    chk("after reset", 4'hC, {g.ss_pulldown, g.comp_clamp,
      g.high_side_gate, g.low_side_gate});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    tick(10);
    @(posedge mclk) resetn <= 1'h1;
    tick(3);
    chk("reset", 4'hC, {g.ss_pulldown, g.comp_clamp, g.high_side_gate,
      g.low_side_gate});
    t_start();
    t_light();
    t_hiccup();
    t_midreset();
    stop_test();
  end
  // the run needs under 1000 cycles; 5000 means a hang
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
